// *** rtl/sds_pkg.sv ***
// Constants, field positions and state types of the sensor diagnostics unit.
// Assumes one core clock and one link clock; serial framing lives outside.

package sds_pkg;

   localparam int        DIN_W         = 16;
   localparam int        ADDR_W        = 7;
   localparam int        DIN_WR_BIT    = 15;
   localparam int        DIN_ADDR_LO   = 8;
   localparam logic [6:0] ADDR_MISC_LO = 7'h34;
   localparam logic [6:0] ADDR_MISC_HI = 7'h35;
   localparam logic [6:0] ADDR_DIAG    = 7'h3c;

   localparam logic [15:0] MISC_RESET  = 16'h0006;
   localparam logic [15:0] MISC_WMASK  = 16'h03c7;
   localparam logic [15:0] DIAG_RESET  = 16'h0000;
   localparam int        MISC_MEM_TEST = 11;
   localparam int        MISC_SELF_TST = 10;
   localparam int        MISC_ST_NEG   = 9;
   localparam int        MISC_ST_POS   = 8;

   localparam int        DG_AXIS_LO    = 10;
   localparam int        DG_ALM2       = 9;
   localparam int        DG_ALM1       = 8;
   localparam int        DG_UNUSED     = 7;
   localparam int        DG_FLASH_CK   = 6;
   localparam int        DG_ST_ERR     = 5;
   localparam int        DG_OVR        = 4;
   localparam int        DG_COMM       = 3;
   localparam int        DG_FL_UPD     = 2;
   localparam int        DG_SUP_HI     = 1;
   localparam int        DG_SUP_LO     = 0;
   localparam int        N_AXES        = 6;

   localparam int        CLK_MHZ       = 200;
   localparam int        ST_SETTLE_MS  = 50;
   localparam int        ST_SETTLE_CYC = ST_SETTLE_MS * CLK_MHZ * 1000;
   localparam int        FL_WORDS_DEF  = 64;

   typedef enum logic [1:0] {ST_IDLE, ST_NEG, ST_POS, ST_DONE} sds_st_t;

endpackage : sds_pkg

// *** rtl/sds_evt_xing.sv ***
// Toggle crossing for single-cycle events between two clocks.
// Assumes events are spaced wider than three destination cycles.
`timescale 1ns/100ps
module sds_evt_xing
(
   input  wire logic src_clk,
   input  wire logic src_rst_n,
   input  wire logic src_pulse,
   input  wire logic dst_clk,
   input  wire logic dst_rst_n,
   output logic      dst_pulse
);
   logic tgl_r, tgl_nxt;
   logic s1_r, s2_r, s3_r;

   always_comb
   begin
      tgl_nxt = tgl_r ^ src_pulse;
   end

   always_ff @(posedge src_clk)
   begin
      if (!src_rst_n) tgl_r <= 1'b0;
      else            tgl_r <= tgl_nxt;
   end

   // First stage feeds only the second
   always_ff @(posedge dst_clk)
   begin
      if (!dst_rst_n)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end
      else
      begin
         s1_r <= tgl_r;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign dst_pulse = s2_r ^ s3_r;
endmodule : sds_evt_xing

// *** rtl/sds_flag_bank.sv ***
// Bank of sticky flags; a set in the clearing cycle wins.
// Assumes set and clear come from the same clock.
`timescale 1ns/100ps
module sds_flag_bank #(parameter int W = 14)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] set,
   input  wire logic         clr,
   output logic      [W-1:0] q
);
   logic [W-1:0] q_r, q_nxt;

   always_comb
   begin
      q_nxt = (clr ? '0 : q_r) | set;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n) q_r <= '0;
      else        q_r <= q_nxt;
   end

   assign q = q_r;
endmodule : sds_flag_bank

// *** rtl/sds_diag.sv ***
// Diagnostics core: self-test sequencer, flash checksum, status flags.
// Assumes a link block hands over decoded 16-bit command words on lk_clk.
`timescale 1ns/100ps
module sds_diag
   import sds_pkg::*;
#(
   parameter int SETTLE_CYC = ST_SETTLE_CYC,
   parameter int FL_WORDS   = FL_WORDS_DEF,
   parameter int FL_AW      = 6
)
(
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             lk_clk,
   input  wire logic             lk_rst_n,
   input  wire logic             lk_din_vld,
   input  wire logic [DIN_W-1:0] lk_din,
   input  wire logic             lk_frame_err,
   output logic                  lk_ready,
   output logic      [DIN_W-1:0] lk_dout,
   output logic                  lk_dout_vld,
   input  wire logic             smp_tick,
   input  wire logic             supply_hi,
   input  wire logic             supply_lo,
   input  wire logic             alarm1,
   input  wire logic             alarm2,
   input  wire logic             over_range,
   input  wire logic             flash_upd_fail,
   input  wire logic [N_AXES-1:0] st_axis_fail,
   output logic                  st_neg,
   output logic                  st_pos,
   output logic      [FL_AW-1:0] fl_addr,
   input  wire logic [DIN_W-1:0] fl_data
);
   localparam int CNT_W = $clog2(SETTLE_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYC - 1);
   localparam logic [FL_AW-1:0] FL_LAST  = FL_AW'(FL_WORDS - 1);

   // Link domain
   logic             lk_busy_r, lk_busy_nxt;
   logic [DIN_W-1:0] lk_word_r, lk_word_nxt;
   logic [DIN_W-1:0] lk_dout_r, lk_dout_nxt;
   logic             lk_vld_r, lk_vld_nxt;
   logic             lk_take, lk_ack;
   logic             req_p, err_p;
   logic [DIN_W-1:0] rdat_r;

   assign lk_ready = !lk_busy_r;
   assign lk_take  = lk_din_vld && !lk_busy_r;

   always_comb
   begin
      lk_busy_nxt = lk_busy_r;
      lk_word_nxt = lk_word_r;
      lk_dout_nxt = lk_dout_r;
      lk_vld_nxt  = 1'b0;
      if (lk_take)
      begin
         lk_busy_nxt = 1'b1;
         lk_word_nxt = lk_din;
      end
      if (lk_ack)
      begin
         lk_busy_nxt = 1'b0;
         lk_dout_nxt = rdat_r;  // Stable until the next acknowledge
         lk_vld_nxt  = 1'b1;
      end
   end

   always_ff @(posedge lk_clk)
   begin
      if (!lk_rst_n)
      begin
         lk_busy_r <= 1'b0;
         lk_word_r <= '0;
         lk_dout_r <= '0;
         lk_vld_r  <= 1'b0;
      end
      else
      begin
         lk_busy_r <= lk_busy_nxt;
         lk_word_r <= lk_word_nxt;
         lk_dout_r <= lk_dout_nxt;
         lk_vld_r  <= lk_vld_nxt;
      end
   end

   assign lk_dout     = lk_dout_r;
   assign lk_dout_vld = lk_vld_r;

   logic ack_src;

   sds_evt_xing u_req (.src_clk(lk_clk), .src_rst_n(lk_rst_n), .src_pulse(lk_take),
                       .dst_clk(mclk), .dst_rst_n(rst_n), .dst_pulse(req_p));
   sds_evt_xing u_ack (.src_clk(mclk), .src_rst_n(rst_n), .src_pulse(ack_src),
                       .dst_clk(lk_clk), .dst_rst_n(lk_rst_n), .dst_pulse(lk_ack));
   sds_evt_xing u_err (.src_clk(lk_clk), .src_rst_n(lk_rst_n), .src_pulse(lk_frame_err),
                       .dst_clk(mclk), .dst_rst_n(rst_n), .dst_pulse(err_p));

   // Supply comparators are asynchronous
   logic [1:0] sup_s1_r, sup_s2_r;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         sup_s1_r <= '0;
         sup_s2_r <= '0;
      end
      else
      begin
         sup_s1_r <= {supply_hi, supply_lo};
         sup_s2_r <= sup_s1_r;
      end
   end

   // Command decode; word held in lk_word_r while busy
   logic             is_wr, wr_lo, wr_hi, rd_diag;
   logic [ADDR_W-1:0] cmd_addr;

   assign cmd_addr = lk_word_r[DIN_WR_BIT-1:DIN_ADDR_LO];
   assign is_wr    = lk_word_r[DIN_WR_BIT];
   assign wr_lo    = req_p && is_wr && cmd_addr == ADDR_MISC_LO;
   assign wr_hi    = req_p && is_wr && cmd_addr == ADDR_MISC_HI;
   assign rd_diag  = req_p && !is_wr && cmd_addr == ADDR_DIAG;

   // Control register and sequencers
   logic [DIN_W-1:0]  misc_r, misc_nxt, rdat_nxt;
   sds_st_t           st_q, st_nxt;
   logic [CNT_W-1:0]  st_cnt_r, st_cnt_nxt;
   logic [N_AXES-1:0] st_fail_r, st_fail_nxt, st_acc_r, st_acc_nxt;
   logic              st_done, mt_done;
   logic              mt_fail_r, mt_fail_nxt;
   logic [FL_AW-1:0]  fl_addr_r, fl_addr_nxt;
   logic [DIN_W-1:0]  fl_sum_r, fl_sum_nxt;
   logic              neg_r, neg_nxt, pos_r, pos_nxt;
   logic [DIN_W-1:0]  diag_w;
   logic              st_start, mt_start;

   assign st_start = wr_hi && lk_word_r[MISC_SELF_TST - DIN_ADDR_LO] && !misc_r[MISC_SELF_TST];
   assign mt_start = wr_hi && lk_word_r[MISC_MEM_TEST - DIN_ADDR_LO] && !misc_r[MISC_MEM_TEST];
   assign st_done  = st_q == ST_DONE;
   assign mt_done  = misc_r[MISC_MEM_TEST] && fl_addr_r == FL_LAST;

   always_comb
   begin
      misc_nxt    = misc_r;
      st_nxt      = st_q;
      st_cnt_nxt  = st_cnt_r;
      st_acc_nxt  = st_acc_r;
      st_fail_nxt = st_fail_r;
      mt_fail_nxt = mt_fail_r;
      fl_addr_nxt = fl_addr_r;
      fl_sum_nxt  = fl_sum_r;
      if (wr_lo)
         misc_nxt[7:0] = (misc_r[7:0] & ~MISC_WMASK[7:0]) | (lk_word_r[7:0] & MISC_WMASK[7:0]);
      if (wr_hi)
         misc_nxt[15:8] = (misc_r[15:8] & ~MISC_WMASK[15:8])
                        | (lk_word_r[7:0] & MISC_WMASK[15:8]);
      if (st_start)
         misc_nxt[MISC_SELF_TST] = 1'b1;
      if (mt_start)
         misc_nxt[MISC_MEM_TEST] = 1'b1;
      case (st_q)
         ST_IDLE:
         begin
            if (st_start)
            begin
               st_nxt     = ST_NEG;
               st_cnt_nxt = '0;
               st_acc_nxt = '0;
            end
         end
         ST_NEG, ST_POS:
         begin
            if (st_cnt_r == CNT_LAST)
            begin
               // Axis judged at the end of each settled phase
               st_acc_nxt = st_acc_r | st_axis_fail;
               st_cnt_nxt = '0;
               st_nxt     = (st_q == ST_NEG) ? ST_POS : ST_DONE;
            end
            else
               st_cnt_nxt = st_cnt_r + 1'b1;
         end
         ST_DONE:
         begin
            st_fail_nxt             = st_acc_r;
            misc_nxt[MISC_SELF_TST] = 1'b0;
            st_nxt                  = ST_IDLE;
         end
         default: st_nxt = ST_IDLE;
      endcase
      // Flash read is combinational; one word per cycle
      if (mt_start)
      begin
         fl_addr_nxt = '0;
         fl_sum_nxt  = '0;
      end
      else if (mt_done)
      begin
         mt_fail_nxt             = fl_sum_r != fl_data;
         misc_nxt[MISC_MEM_TEST] = 1'b0;
         fl_addr_nxt             = '0;
      end
      else if (misc_r[MISC_MEM_TEST])
      begin
         fl_sum_nxt  = fl_sum_r + fl_data;
         fl_addr_nxt = fl_addr_r + 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         misc_r    <= MISC_RESET;
         st_q      <= ST_IDLE;
         st_cnt_r  <= '0;
         st_acc_r  <= '0;
         st_fail_r <= '0;
         mt_fail_r <= 1'b0;
         fl_addr_r <= '0;
         fl_sum_r  <= '0;
      end
      else
      begin
         misc_r    <= misc_nxt;
         st_q      <= st_nxt;
         st_cnt_r  <= st_cnt_nxt;
         st_acc_r  <= st_acc_nxt;
         st_fail_r <= st_fail_nxt;
         mt_fail_r <= mt_fail_nxt;
         fl_addr_r <= fl_addr_nxt;
         fl_sum_r  <= fl_sum_nxt;
      end
   end

   // Stimulus: manual bits or the running routine
   always_comb
   begin
      neg_nxt = misc_r[MISC_ST_NEG] || st_q == ST_NEG;
      pos_nxt = misc_r[MISC_ST_POS] || st_q == ST_POS;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         neg_r <= 1'b0;
         pos_r <= 1'b0;
      end
      else
      begin
         neg_r <= neg_nxt;
         pos_r <= pos_nxt;
      end
   end

   assign st_neg  = neg_r;
   assign st_pos  = pos_r;
   assign fl_addr = fl_addr_r;

   // Error flags: conditions re-arm on each sample
   logic [DIN_W-1:2] flag_set, flag_q;
   logic [1:0]       sup_r, sup_nxt;

   always_comb
   begin
      flag_set = '0;
      if (smp_tick)
      begin
         flag_set[DIN_W-1:DG_AXIS_LO] = st_fail_r;
         flag_set[DG_ALM2]            = alarm2;
         flag_set[DG_ALM1]            = alarm1;
         flag_set[DG_FLASH_CK]        = mt_fail_r;
         flag_set[DG_ST_ERR]          = |st_fail_r;
         flag_set[DG_OVR]             = over_range;
         flag_set[DG_FL_UPD]          = flash_upd_fail;
      end
      if (st_done)
      begin
         flag_set[DIN_W-1:DG_AXIS_LO] = flag_set[DIN_W-1:DG_AXIS_LO] | st_acc_r;
         flag_set[DG_ST_ERR]          = flag_set[DG_ST_ERR] | (|st_acc_r);
      end
      if (mt_done)
         flag_set[DG_FLASH_CK] = flag_set[DG_FLASH_CK] | (fl_sum_r != fl_data);
      flag_set[DG_COMM] = err_p;
      // Supply flags follow the comparators, reads leave them alone
      sup_nxt = smp_tick ? sup_s2_r : sup_r;
   end

   sds_flag_bank #(.W(DIN_W - 2)) u_flags
   (
      .clk   (mclk),
      .rst_n (rst_n),
      .set   (flag_set),
      .clr   (rd_diag),
      .q     (flag_q)
   );

   always_ff @(posedge mclk)
   begin
      if (!rst_n) sup_r <= DIAG_RESET[1:0];
      else        sup_r <= sup_nxt;
   end

   // Bit 7 has no source
   assign diag_w = {flag_q[DIN_W-1:DG_ALM1], 1'b0, flag_q[DG_FLASH_CK:DG_FL_UPD], sup_r};

   // Read data captured with the clear, then acknowledged
   always_comb
   begin
      rdat_nxt = rdat_r;
      if (req_p && !is_wr)
      begin
         if (cmd_addr == ADDR_DIAG)
            rdat_nxt = diag_w;
         else if (cmd_addr == ADDR_MISC_LO || cmd_addr == ADDR_MISC_HI)
            rdat_nxt = misc_r;
         else
            rdat_nxt = '0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n) rdat_r <= '0;
      else        rdat_r <= rdat_nxt;
   end

   logic ack_r;

   always_ff @(posedge mclk)
   begin
      if (!rst_n) ack_r <= 1'b0;
      else        ack_r <= req_p;
   end

   assign ack_src = ack_r;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence neg_end_s;
      st_q == ST_NEG && st_cnt_r == CNT_LAST;
   endsequence

   sequence pos_start_s;
      st_q == ST_POS ##1 st_pos;
   endsequence

   st_start_a: assert property (st_start |=> st_q == ST_NEG ##1 st_neg)
      else $error("self-test did not start negative phase");
   st_phase_a: assert property (neg_end_s |=> pos_start_s)
      else $error("self-test did not move to positive phase");
   st_clear_a: assert property ($fell(misc_r[MISC_SELF_TST]) |-> $past(st_q) == ST_DONE)
      else $error("self-test bit cleared outside completion");
   st_run_a: assert property (misc_r[MISC_SELF_TST] |-> st_q != ST_IDLE)
      else $error("self-test bit set while idle");
   man_stim_a: assert property (misc_r[MISC_ST_NEG] |=> st_neg)
      else $error("manual negative stimulus not applied");
   mt_clear_a: assert property (mt_done |=> !misc_r[MISC_MEM_TEST])
      else $error("memory test bit not cleared");
   mt_flag_a: assert property (mt_done && fl_sum_r != fl_data |=> diag_w[DG_FLASH_CK])
      else $error("checksum failure not flagged");
   rd_clear_a: assert property (rd_diag && flag_set == '0 |=> diag_w[DIN_W-1:2] == '0)
      else $error("status read did not clear flags");
   sup_keep_a: assert property (rd_diag && !smp_tick |=> $stable(sup_r))
      else $error("supply flags changed on read");
   rearm_ovr_a: assert property (smp_tick && over_range |=> diag_w[DG_OVR])
      else $error("overrange flag not re-armed");
   comm_err_a: assert property (err_p |=> diag_w[DG_COMM])
      else $error("comm failure not flagged");
   unused_zero_a: assert property (diag_w[DG_UNUSED] == 1'b0)
      else $error("unused status bit set");
   diag_reset_a: assert property (@(posedge mclk) disable iff (1'b0)
      !rst_n |=> diag_w == DIAG_RESET)
      else $error("status not zero after reset");
endmodule : sds_diag

// *** bench/sds_host_model.sv ***
// Host model: offers command words on the link and gates the link clock.
// Assumes one caller at a time; the clock stands still between calls.
`timescale 1ns/100ps
module sds_host_model
(
   input  wire logic        lk_ready,
   input  wire logic [15:0] lk_dout,
   input  wire logic        lk_dout_vld,
   output logic             lk_clk,
   output logic             lk_din_vld,
   output logic      [15:0] lk_din,
   output logic             lk_frame_err
);
   initial
   begin
      lk_clk       = 1'b0;
      lk_din_vld   = 1'b0;
      lk_din       = 16'h0000;
      lk_frame_err = 1'b0;
   end

   task automatic idle(input int n);
      repeat (n)
      begin
         #3 lk_clk = 1'b1;
         #3 lk_clk = 1'b0;
      end
   endtask : idle

   // Word held until taken, then released to its inverse, not left stale
   task automatic xfer(input logic [15:0] w, output logic ok);
      int   n;
      logic tk;
      logic rel;
      n  = 0;
      tk = 1'b0;
      ok = 1'b0;
      #1.7 lk_din = w;
      lk_din_vld = 1'b1;
      while (!ok && n < 100)
      begin
         ok  = tk && (lk_dout_vld === 1'b1);
         rel = !tk && (lk_ready === 1'b1);
         #3 lk_clk = 1'b1;
         #0.5;
         if (rel)
         begin
            tk         = 1'b1;
            lk_din_vld = 1'b0;
            lk_din     = ~w;
         end
         #2.5 lk_clk = 1'b0;
         n++;
      end
   endtask : xfer

   // One-cycle failed-transaction pulse, then a few edges for the crossing
   task automatic frame_err;
      lk_frame_err = 1'b1;
      #3 lk_clk = 1'b1;
      #0.5 lk_frame_err = 1'b0;
      #2.5 lk_clk = 1'b0;
      idle(4);
   endtask : frame_err
endmodule : sds_host_model

// *** bench/tb_sensor_diagnostics_status.sv ***
// Self-checking bench for the diagnostics core, host model on the link.
// Assumes short settle and flash sizes; mclk-side inputs change on falling edges.
`timescale 1ns/100ps
module tb_sensor_diagnostics_status
   import sds_pkg::*;
();
   typedef struct packed {logic [15:0] v; logic [15:0] m;} sds_exp_t;
   logic        mclk, rst_n, lk_rst_n, smp_tick, st_neg, st_pos, ok, saw_neg, saw_pos;
   logic        lk_clk, lk_din_vld, lk_frame_err, lk_ready, lk_dout_vld;
   logic [15:0] lk_din, lk_dout, misc_e, sum;
   logic [5:0]  st_axis_fail, fail_e;
   logic [4:0]  fl_addr;
   logic [3:0]  cond;
   logic [1:0]  sup;
   logic [15:0] flash [32];
   logic [15:0] cbit [4] = '{16'h0100, 16'h0200, 16'h0010, 16'h0004};
   logic [15:0] man [6] = '{16'hb601, 16'hb904, 16'hb802, 16'hb502, 16'hb501, 16'hb500};
   sds_exp_t    q [$];
   int          n_errors = 0;
   int          n_checks = 0;

   sds_diag #(.SETTLE_CYC(20), .FL_WORDS(32), .FL_AW(5)) uut
   (
      .mclk, .rst_n, .lk_clk, .lk_rst_n, .lk_din_vld, .lk_din, .lk_frame_err, .lk_ready,
      .lk_dout, .lk_dout_vld, .smp_tick, .supply_hi(sup[1]), .supply_lo(sup[0]),
      .alarm1(cond[0]), .alarm2(cond[1]), .over_range(cond[2]), .flash_upd_fail(cond[3]),
      .st_axis_fail, .st_neg, .st_pos, .fl_addr, .fl_data(flash[fl_addr])
   );

   sds_host_model host
   (
      .lk_ready, .lk_dout, .lk_dout_vld, .lk_clk, .lk_din_vld, .lk_din, .lk_frame_err
   );

   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;

   always @(posedge mclk)
   begin
      if (st_neg === 1'b1) saw_neg = 1'b1;
      if (st_pos === 1'b1) saw_pos = 1'b1;
   end

   task automatic bad(input string s);
      n_errors++;
      $display("BAD t=%0t %s", $time, s);
   endtask : bad

   task automatic chk_word(input logic [15:0] got, input sds_exp_t e);
      n_checks++;
      if (((got ^ e.v) & e.m) !== 16'h0000) bad($sformatf("word %h exp %h", got, e.v));
   endtask : chk_word

   task automatic chk_pin(input logic got, input logic exp, input string s);
      n_checks++;
      if (got !== exp) bad(s);
   endtask : chk_pin

   // Answers compared as they appear, oldest note first
   always @(posedge lk_clk)
      if (lk_dout_vld === 1'b1)
      begin
         if (q.size() == 0) bad("unexpected answer");
         else chk_word(lk_dout, q.pop_front());
      end

   task automatic io(input logic [15:0] w, input logic [15:0] v, input logic [15:0] m);
      q.push_back('{v, m});
      host.xfer(w, ok);
      if (!ok) bad("no answer");
      repeat (4) @(negedge mclk);
   endtask : io

   task automatic rd_stat(input logic [15:0] v);
      io(16'h3c00, v, 16'hffff);
   endtask : rd_stat

   task automatic smp;
      repeat (3) @(negedge mclk);
      smp_tick = 1'b1;
      @(negedge mclk) smp_tick = 1'b0;
      repeat (3) @(negedge mclk);
   endtask : smp

   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   initial
   begin
      #100000;
      bad("watchdog expired");
      report_and_stop();
   end

   initial
   begin
      {rst_n, lk_rst_n, smp_tick, cond, sup, st_axis_fail} = '0;
      foreach (flash[a]) flash[a] = 16'h0000;
      void'($urandom(32'h5980e0a5));
      fork
         host.idle(6);
         repeat (4) @(negedge mclk);
      join
      @(negedge mclk) {rst_n, lk_rst_n} = 2'b11;
      host.idle(2);
      repeat (4) @(negedge mclk);
      rd_stat(DIAG_RESET);
      io(16'h3400, MISC_RESET, 16'hffff);
      $display("done reset");
      // Unmapped address reads back as zero
      misc_e = MISC_RESET;
      io(16'h0400, 16'h0000, 16'hffff);
      // Low byte write path; only writable bits may land
      misc_e[7:0] = 8'($urandom);
      io({8'hb4, misc_e[7:0]}, 16'h0000, 16'h0000);
      misc_e[7:0] = misc_e[7:0] & MISC_WMASK[7:0];
      io(16'h3400, misc_e, 16'hffff);
      io(16'hb406, 16'h0000, 16'h0000);
      misc_e = MISC_RESET;
      foreach (man[j])
      begin
         io(man[j], 16'h0000, 16'h0000);
         if (man[j][14:8] == ADDR_MISC_HI) misc_e[15:8] = man[j][7:0];
         io(16'h3400, misc_e, 16'hffff);
         chk_pin(st_neg, misc_e[MISC_ST_NEG], "negative stimulus");
         chk_pin(st_pos, misc_e[MISC_ST_POS], "positive stimulus");
      end
      $display("done manual");
      // Device at rest: no range or alarm input raised during self-tests
      for (int k = 0; k < 2; k++)
      begin
         fail_e = (k == 0) ? (6'($urandom) | 6'h01) : 6'h00;
         {saw_neg, saw_pos} = 2'b00;
         @(negedge mclk) st_axis_fail = fail_e;
         io(16'hb504, 16'h0000, 16'h0000);
         io(16'h3400, 16'h0406, 16'hffff);
         repeat (120) @(negedge mclk);
         io(16'h3400, 16'h0006, 16'hffff);
         chk_pin(saw_neg & saw_pos, 1'b1, "no stimulus phases");
         smp();
         rd_stat({fail_e, 4'h0, |fail_e, 5'h00});
         smp();
         rd_stat({fail_e, 4'h0, |fail_e, 5'h00});
      end
      $display("done self-test");
      for (int i = 0; i < 4; i++)
      begin
         @(negedge mclk) cond[i] = 1'b1;
         smp();
         rd_stat(cbit[i]);
         rd_stat(16'h0000);
         smp();
         rd_stat(cbit[i]);
         @(negedge mclk) cond[i] = 1'b0;
         smp();
         rd_stat(16'h0000);
      end
      host.frame_err();
      smp();
      rd_stat(16'h0008);
      rd_stat(16'h0000);
      for (int i = 0; i < 2; i++)
      begin
         @(negedge mclk) sup[i] = 1'b1;
         smp();
         rd_stat(16'h0001 << i);
         rd_stat(16'h0001 << i);
         @(negedge mclk) sup[i] = 1'b0;
         smp();
         rd_stat(16'h0000);
      end
      $display("done flags");
      for (int k = 0; k < 2; k++)
      begin
         sum = 16'h0000;
         for (int a = 0; a < 31; a++)
         begin
            flash[a] = 16'($urandom);
            sum      = sum + flash[a];
         end
         flash[31] = sum ^ 16'(k);
         io(16'hb508, 16'h0000, 16'h0000);
         io(16'h3400, 16'h0806, 16'hffff);
         repeat (120) @(negedge mclk);
         io(16'h3400, 16'h0006, 16'hffff);
         smp();
         rd_stat(16'(k) << DG_FLASH_CK);
      end
      $display("done memory test");
      report_and_stop();
   end
endmodule : tb_sensor_diagnostics_status
